// >>> hw/tcm_capture_prescaler.sv
// Purpose: Edge select and capture prescaler for one input channel
// Assumes: level is the filtered channel input
// Notes:   Counter is held clear while the capture is disabled
`default_nettype none

module tcm_capture_prescaler (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       enable,
    input  wire logic       polarity,
    input  wire logic [1:0] ratio,
    input  wire logic       level,
    output logic            trig_q,
    output logic            capture_q
);

    logic       lvl;
    logic       edge_w;
    logic       last;
    logic [2:0] count_q;
    logic [2:0] top;

    assign lvl    = level ^ polarity; // R14
    assign edge_w = lvl & ~trig_q; // R14

    always_comb begin
        case (ratio)
            2'h0:    top = 3'h0;
            2'h1:    top = 3'h1;
            2'h2:    top = 3'h3;
            default: top = 3'h7;
        endcase
    end

    assign last = count_q >= top; // R13

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_q    <= 1'b0;
            count_q   <= 3'h0;
            capture_q <= 1'b0;
        end else begin
            trig_q    <= lvl;
            capture_q <= enable & edge_w & last;
            if (!enable) begin
                count_q <= 3'h0; // R13
            end else if (edge_w) begin
                count_q <= last ? 3'h0 : count_q + 3'h1; // R13
            end
        end
    end

    property p_psc_clear;
        @(posedge aclk) disable iff (!aresetn)
        !enable |=> (count_q == 3'h0) && !capture_q;
    endproperty
    a_psc_clear: assert property (p_psc_clear) else $error("prescaler not cleared"); // R13

    property p_cap_edge;
        @(posedge aclk) disable iff (!aresetn)
        capture_q |-> $past(edge_w) && $past(enable);
    endproperty
    a_cap_edge: assert property (p_cap_edge) else $error("capture without edge"); // R14

endmodule

`default_nettype wire

// >>> hw/tcm_input_filter.sv
// Purpose: Digital input filter, flips output after N equal samples
// Assumes: Dead-time and kernel clock both equal aclk
// Notes:   div_cnt is a free-running counter shared by both channels
`default_nettype none

module tcm_input_filter (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [3:0] setting,
    input  wire logic [4:0] div_cnt,
    input  wire logic       sample_in,
    output logic            filtered_q
);

    logic [3:0] need;
    logic [4:0] mask;
    logic [3:0] cnt_q;
    logic       sample_en;

    // Sampling divider mask and count of equal samples
    always_comb begin
        case (setting)
            4'h0:    begin mask = 5'h00; need = 4'h1; end
            4'h1:    begin mask = 5'h00; need = 4'h2; end
            4'h2:    begin mask = 5'h00; need = 4'h4; end
            4'h3:    begin mask = 5'h00; need = 4'h8; end
            4'h4:    begin mask = 5'h01; need = 4'h6; end
            4'h5:    begin mask = 5'h01; need = 4'h8; end
            4'h6:    begin mask = 5'h03; need = 4'h6; end
            4'h7:    begin mask = 5'h03; need = 4'h8; end
            4'h8:    begin mask = 5'h07; need = 4'h6; end
            4'h9:    begin mask = 5'h07; need = 4'h8; end
            4'ha:    begin mask = 5'h0f; need = 4'h5; end
            4'hb:    begin mask = 5'h0f; need = 4'h6; end
            4'hc:    begin mask = 5'h0f; need = 4'h8; end
            4'hd:    begin mask = 5'h1f; need = 4'h5; end
            4'he:    begin mask = 5'h1f; need = 4'h6; end
            default: begin mask = 5'h1f; need = 4'h8; end
        endcase
    end

    assign sample_en = (div_cnt & mask) == 5'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q      <= 4'h0;
            filtered_q <= 1'b0;
        end else if (sample_en) begin
            if (sample_in == filtered_q) begin
                cnt_q <= 4'h0; // R12
            end else if (cnt_q + 4'h1 >= need) begin
                cnt_q      <= 4'h0;
                filtered_q <= sample_in; // R12
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    property p_filter_cause;
        @(posedge aclk) disable iff (!aresetn)
        (filtered_q != $past(filtered_q)) |-> ($past(sample_in) == filtered_q);
    endproperty
    a_filter_cause: assert property (p_filter_cause) else $error("filter moved without input"); // R12

endmodule

`default_nettype wire

// >>> hw/tcm_mode_config.sv
// Purpose: Mode configuration and input routing for timer channels 3 and 4
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes:   Direction select is frozen while its channel is enabled
// Functional notes
// R1 - Ch4 output fields at bits 15..8
// R2 - Ch3 output fields at bits 7..0
// R3 - Ch4 input filter 15:12, prescaler 11:10
// R4 - Ch3 input filter 7:4, prescaler 3:2
// R5 - Ch4 select: output, own, neighbour input
// R6 - Ch4 select 11 routes internal trigger
// R7 - Ch3 select: output, own, neighbour input
// R8 - Ch3 select 11 routes internal trigger
// R9 - Ch4 select locked while channel enabled
// R10 - Ch3 select locked while channel enabled
// R11 - Upper six bits follow channel direction
// R12 - Filter flips after N equal samples
// R13 - Prescaler divides captures, cleared when disabled
// R14 - Polarity picks capture edge and trigger
//
// Our own choice: the AXI4-Lite interface to the registers.
`default_nettype none

module tcm_mode_config (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        timer_input_three,
    input  wire logic        timer_input_four,
    input  wire logic        internal_trigger_signal,
    output logic             ch3_filtered_input,
    output logic             ch4_filtered_input,
    output logic             ch3_capture_event,
    output logic             ch4_capture_event,
    output logic             ch3_channel_enable,
    output logic             ch4_channel_enable,
    output logic [2:0]       ch3_compare_mode,
    output logic [2:0]       ch4_compare_mode,
    output logic             ch3_compare_clear_enable,
    output logic             ch4_compare_clear_enable,
    output logic             ch3_compare_preload_enable,
    output logic             ch4_compare_preload_enable,
    output logic             ch3_compare_fast_enable,
    output logic             ch4_compare_fast_enable
);

    // Register state
    logic [15:0] mode_q;
    logic [15:0] mode_d;
    logic [15:0] enpol_q;
    logic [15:0] slave_q;
    logic [4:0]  div_q;

    // Write channel state
    logic        aw_held_q;
    logic [11:0] awaddr_q;
    logic        w_held_q;
    logic [15:0] wdata_q;
    logic [1:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;

    // Read channel state
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // Decode
    logic        do_write;
    logic        wr_mode;
    logic        wr_enpol;
    logic        wr_slave;
    logic        wr_hit;
    logic        rd_take;
    logic        rd_mode;
    logic        rd_enpol;
    logic        rd_slave;
    logic        rd_status;
    logic [15:0] rd_mux;
    logic        itr_sel;
    logic [15:0] status_w;

    // Per channel signals, index 0 is channel 3, index 1 is channel 4
    logic [1:0]  ti;
    logic [1:0]  ch_en;
    logic [1:0]  ch_pol;
    logic [1:0]  raw;
    logic [1:0]  filt;
    logic [1:0]  trig;
    logic [1:0]  cap;
    logic [1:0]  is_in;
    logic [5:0]  oc_q [2];

    assign ti      = {timer_input_four, timer_input_three};
    assign itr_sel = slave_q[tcm_pkg::TRIGGER_SOURCE_SELECT_LSB +: 3] <= tcm_pkg::TRIGGER_SOURCE_SELECT_INTERNAL_MAX;

    // Only channels 3 and 4 report status, the upper byte reads zero
    assign status_w[15:8] = 8'h00;

    // Write path: address and data taken in either order
    assign awready  = ~aw_held_q & ~bvalid_q;
    assign wready   = ~w_held_q & ~bvalid_q;
    assign do_write = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_mode  = do_write & (awaddr_q[11:2] == tcm_pkg::ADDR_MODE[11:2]);
    assign wr_enpol = do_write & (awaddr_q[11:2] == tcm_pkg::ADDR_ENPOL[11:2]);
    assign wr_slave = do_write & (awaddr_q[11:2] == tcm_pkg::ADDR_SLAVE[11:2]);
    assign wr_hit   = wr_mode | wr_enpol | wr_slave
                    | (awaddr_q[11:2] == tcm_pkg::ADDR_STATUS[11:2]);
    assign bvalid   = bvalid_q;
    assign bresp    = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 12'h000;
        end else if (awvalid & awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q  <= 16'h0000;
            wstrb_q  <= 2'h0;
        end else if (wvalid & wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= wdata[15:0];
            wstrb_q  <= wstrb[1:0];
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= tcm_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? tcm_pkg::RESP_OKAY : tcm_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Registers steered by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q  <= tcm_pkg::MODE_RESET;
            enpol_q <= tcm_pkg::ENPOL_RESET;
            slave_q <= tcm_pkg::SLAVE_RESET;
        end else begin
            mode_q <= mode_d;
            if (wr_enpol & wstrb_q[1]) begin
                enpol_q <= wdata_q & tcm_pkg::ENPOL_MASK;
            end
            if (wr_slave & wstrb_q[0]) begin
                slave_q <= wdata_q & tcm_pkg::SLAVE_MASK;
            end
        end
    end

    // Sampling divider for the input filters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 5'h00;
        end else begin
            div_q <= div_q + 5'h01;
        end
    end

    // Read path
    assign arready   = ~rvalid_q;
    assign rd_take   = arvalid & arready;
    assign rd_mode   = araddr[11:2] == tcm_pkg::ADDR_MODE[11:2];
    assign rd_enpol  = araddr[11:2] == tcm_pkg::ADDR_ENPOL[11:2];
    assign rd_slave  = araddr[11:2] == tcm_pkg::ADDR_SLAVE[11:2];
    assign rd_status = araddr[11:2] == tcm_pkg::ADDR_STATUS[11:2];
    assign rd_mux    = ({16{rd_mode}} & mode_q) | ({16{rd_enpol}} & enpol_q)
                     | ({16{rd_slave}} & slave_q) | ({16{rd_status}} & status_w);
    assign rvalid    = rvalid_q;
    assign rdata     = rdata_q;
    assign rresp     = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= tcm_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {16'h0000, rd_mux};
            rresp_q  <= (rd_mode | rd_enpol | rd_slave | rd_status)
                      ? tcm_pkg::RESP_OKAY : tcm_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            localparam int B = c * tcm_pkg::CH_STRIDE;
            logic [1:0] dir;
            logic       src_ok;
            logic       raw_pick;

            assign ch_en[c]  = enpol_q[tcm_pkg::ENPOL_LSB + c * tcm_pkg::ENPOL_STRIDE + tcm_pkg::EN_OFS];
            assign ch_pol[c] = enpol_q[tcm_pkg::ENPOL_LSB + c * tcm_pkg::ENPOL_STRIDE + tcm_pkg::POL_OFS];
            assign dir       = mode_q[B + tcm_pkg::SEL_LSB +: 2];
            assign is_in[c]  = dir != tcm_pkg::TCM_DIR_OUT; // R11

            // Byte update: direction bits frozen while the channel is on
            assign mode_d[B + 2 +: 6] = (wr_mode & wstrb_q[c])
                                      ? wdata_q[B + 2 +: 6] : mode_q[B + 2 +: 6];
            assign mode_d[B +: 2] = (wr_mode & wstrb_q[c] & ~ch_en[c])
                                  ? wdata_q[B +: 2] : mode_q[B +: 2]; // R9 R10

            // Input routing
            assign src_ok = (dir != tcm_pkg::TCM_DIR_TRIG) | itr_sel; // R6 R8
            always_comb begin
                case (dir)
                    tcm_pkg::TCM_DIR_OWN:   raw_pick = ti[c]; // R5 R7
                    tcm_pkg::TCM_DIR_NEIGH: raw_pick = ti[1 - c]; // R5 R7
                    tcm_pkg::TCM_DIR_TRIG:  raw_pick = internal_trigger_signal; // R6 R8
                    default:                raw_pick = 1'b0;
                endcase
            end
            assign raw[c] = raw_pick & src_ok;

            tcm_input_filter u_filter (
                .aclk       (aclk),
                .aresetn    (aresetn),
                .setting    (mode_q[B + tcm_pkg::FLT_LSB +: 4]), // R3 R4
                .div_cnt    (div_q),
                .sample_in  (raw[c]),
                .filtered_q (filt[c])
            );

            tcm_capture_prescaler u_psc (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .enable    (ch_en[c] & is_in[c]),
                .polarity  (ch_pol[c]),
                .ratio     (mode_q[B + tcm_pkg::PSC_LSB +: 2]), // R3 R4
                .level     (filt[c]),
                .trig_q    (trig[c]),
                .capture_q (cap[c])
            );

            // Output compare settings only while the channel is an output
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    oc_q[c] <= 6'h00;
                end else begin
                    oc_q[c] <= is_in[c] ? 6'h00 : mode_q[B + tcm_pkg::OC_LSB +: 6]; // R1 R2 R11
                end
            end

            assign status_w[c * tcm_pkg::STAT_STRIDE +: tcm_pkg::STAT_STRIDE] =
                {1'b0, is_in[c], src_ok & is_in[c], filt[c]};

            property p_sel_locked;
                @(posedge aclk) disable iff (!aresetn)
                (ch_en[c] & wr_mode) |=> dir == $past(dir);
            endproperty
            a_sel_locked: assert property (p_sel_locked) else $error("select changed while on"); // R9 R10

            property p_route_own;
                @(posedge aclk) disable iff (!aresetn)
                dir == tcm_pkg::TCM_DIR_OWN |-> raw[c] == ti[c];
            endproperty
            a_route_own: assert property (p_route_own) else $error("own input not routed"); // R5 R7

            property p_route_neigh;
                @(posedge aclk) disable iff (!aresetn)
                dir == tcm_pkg::TCM_DIR_NEIGH |-> raw[c] == ti[1 - c];
            endproperty
            a_route_neigh: assert property (p_route_neigh) else $error("neighbour not routed"); // R5 R7

            property p_route_trig;
                @(posedge aclk) disable iff (!aresetn)
                dir == tcm_pkg::TCM_DIR_TRIG |-> raw[c] == (internal_trigger_signal & itr_sel);
            endproperty
            a_route_trig: assert property (p_route_trig) else $error("trigger routing wrong"); // R6 R8

            property p_oc_fields;
                @(posedge aclk) disable iff (!aresetn)
                !is_in[c] |=> oc_q[c] == $past(mode_q[B + 2 +: 6]);
            endproperty
            a_oc_fields: assert property (p_oc_fields) else $error("compare fields wrong"); // R1 R2

            property p_ic_blank;
                @(posedge aclk) disable iff (!aresetn)
                is_in[c] |=> oc_q[c] == 6'h00;
            endproperty
            a_ic_blank: assert property (p_ic_blank) else $error("compare fields in input"); // R11
        end
    endgenerate

    sequence s_both_held;
        aw_held_q && w_held_q && !bvalid_q;
    endsequence

    sequence s_resp_hold;
        bvalid_q && !awready && !wready;
    endsequence

    property p_write_resp;
        @(posedge aclk) disable iff (!aresetn)
        s_both_held |=> s_resp_hold;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response lost");

    assign ch3_filtered_input         = trig[0];
    assign ch4_filtered_input         = trig[1];
    assign ch3_capture_event          = cap[0];
    assign ch4_capture_event          = cap[1];
    assign ch3_channel_enable         = ch_en[0];
    assign ch4_channel_enable         = ch_en[1];
    assign ch3_compare_fast_enable    = oc_q[0][0];
    assign ch3_compare_preload_enable = oc_q[0][1];
    assign ch3_compare_mode           = oc_q[0][4:2];
    assign ch3_compare_clear_enable   = oc_q[0][5];
    assign ch4_compare_fast_enable    = oc_q[1][0];
    assign ch4_compare_preload_enable = oc_q[1][1];
    assign ch4_compare_mode           = oc_q[1][4:2];
    assign ch4_compare_clear_enable   = oc_q[1][5];

endmodule

`default_nettype wire

// >>> hw/tcm_pkg.sv
// Purpose: Shared constants for the channel 3/4 mode configuration block
// Assumes: 32-bit AXI4-Lite register bus, 12-bit byte addresses
// Notes:   Each channel owns one byte of the mode register
`default_nettype none

package tcm_pkg;

    // Byte addresses
    localparam logic [11:0] ADDR_SLAVE  = 12'h008;
    localparam logic [11:0] ADDR_MODE   = 12'h01c;
    localparam logic [11:0] ADDR_ENPOL  = 12'h020;
    localparam logic [11:0] ADDR_STATUS = 12'h030;

    // Values after reset and writable masks
    localparam logic [15:0] MODE_RESET  = 16'h0000;
    localparam logic [15:0] ENPOL_RESET = 16'h0000;
    localparam logic [15:0] SLAVE_RESET = 16'h0000;
    localparam logic [15:0] ENPOL_MASK  = 16'h3300;
    localparam logic [15:0] SLAVE_MASK  = 16'h0070;

    // Field positions inside one channel byte
    localparam int CH_STRIDE = 8;
    localparam int SEL_LSB   = 0;
    localparam int PSC_LSB   = 2;
    localparam int FLT_LSB   = 4;
    localparam int OC_LSB    = 2;

    // Enable/polarity nibbles, trigger source select field
    localparam int ENPOL_LSB    = 8;
    localparam int ENPOL_STRIDE = 4;
    localparam int EN_OFS       = 0;
    localparam int POL_OFS      = 1;
    localparam int TRIGGER_SOURCE_SELECT_LSB     = 4;
    localparam logic [2:0] TRIGGER_SOURCE_SELECT_INTERNAL_MAX = 3'h3;

    // Status nibble per channel
    localparam int STAT_STRIDE = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TCM_DIR_OUT,
        TCM_DIR_OWN,
        TCM_DIR_NEIGH,
        TCM_DIR_TRIG
    } tcm_dir_e;

endpackage

`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the channel 3/4 mode configuration block
// Assumes: Register access over AXI4-Lite, pins from tcm_pin_model
// Notes:   Expected values come from the field layout, never from the design
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [2:0]  want = 3'h0, m3, m4;
    logic        awready, wready, bvalid, arready, rvalid, ti3, ti4, trg, seen3 = 1'b0;
    logic [1:0]  bresp, rresp, resp;
    logic        f3, f4, e3, e4, en3, en4, cc3, cc4, pe3, pe4, fe3, fe4;
    int          err_total = 0, checks_done = 0, c, s, src;
    int          cap[2] = '{0, 0};

    tcm_mode_config tcm_mode_config_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .timer_input_three(ti3), .timer_input_four(ti4),
        .internal_trigger_signal(trg), .ch3_filtered_input(f3), .ch4_filtered_input(f4),
        .ch3_capture_event(e3), .ch4_capture_event(e4), .ch3_channel_enable(en3), .ch4_channel_enable(en4),
        .ch3_compare_mode(m3), .ch4_compare_mode(m4), .ch3_compare_clear_enable(cc3),
        .ch4_compare_clear_enable(cc4), .ch3_compare_preload_enable(pe3), .ch4_compare_preload_enable(pe4),
        .ch3_compare_fast_enable(fe3), .ch4_compare_fast_enable(fe4)
    );

    tcm_pin_model tcm_pin_model_i (.aclk(aclk), .want(want), .pin_three(ti3), .pin_four(ti4), .trig(trg));

    always #2 aclk = ~aclk;

    always @(posedge aclk) begin
        if (e3 === 1'b1) cap[0]++;
        if (e4 === 1'b1) cap[1]++;
        if (f3 === 1'b1) seen3 <= 1'b1;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 60) begin
            err_total++;
            $display("FAIL %0t wait ran out", $time);
            complete_run();
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 60 && !(bvalid && bready); n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        tmo(n);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 60 && !(rvalid && rready); n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        tmo(n);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    function automatic logic fo(input int ch);
        return (ch != 0) ? f4 : f3;
    endfunction

    task automatic wait_out(input int ch, input logic e);
        int n;
        for (n = 0; n < 60 && fo(ch) !== e; n++) @(posedge aclk);
        tmo(n);
        chk(fo(ch), e);
    endtask

    task automatic pulse(input int idx, input int cnt, input int w);
        repeat (cnt) begin
            @(posedge aclk);
            want[idx] <= 1'b1;
            idle(w);
            want[idx] <= 1'b0;
            idle(w);
        end
    endtask

    initial begin
        idle(6);
        aresetn <= 1'b1;
        rd_reg(tcm_pkg::ADDR_MODE);
        chk(rd, 32'(tcm_pkg::MODE_RESET));
        chk(resp, tcm_pkg::RESP_OKAY);
        // Output compare fields of both channels
        wr(tcm_pkg::ADDR_MODE, 32'h0000d4b8);
        chk(resp, tcm_pkg::RESP_OKAY);
        idle(3);
        chk({cc4, m4, pe4, fe4}, 6'h35);
        chk({cc3, m3, pe3, fe3}, 6'h2e);
        rd_reg(tcm_pkg::ADDR_MODE);
        chk(rd, 32'h0000d4b8);
        // Upper bits of both channels read as filter and prescaler once inputs
        wr(tcm_pkg::ADDR_MODE, 32'h0000f5f5);
        idle(3);
        chk({cc4, m4, pe4, fe4, cc3, m3, pe3, fe3}, 12'h000);
        rd_reg(tcm_pkg::ADDR_MODE);
        chk(rd, 32'h0000f5f5);
        // Every input routing of both channels
        for (c = 0; c < 2; c++) begin
            for (s = 1; s < 4; s++) begin
                src = (s == 3) ? 2 : (s == 1) ? c : 1 - c;
                wr(tcm_pkg::ADDR_MODE, 32'(s) << (8 * c));
                want <= 3'(1 << src);
                wait_out(c, 1'b1);
                want <= 3'h7 ^ 3'(1 << src);
                wait_out(c, 1'b0);
            end
        end
        // Trigger routing dead while an external source is selected
        wr(tcm_pkg::ADDR_MODE, 32'h0303);
        wr(tcm_pkg::ADDR_SLAVE, 32'h40);
        want <= 3'h4;
        idle(20);
        chk({f4, f3}, 2'b00);
        wr(tcm_pkg::ADDR_SLAVE, 32'h0);
        want <= 3'h0;
        // Direction select locked while enabled, other bits still written
        wr(tcm_pkg::ADDR_MODE, 32'h0101);
        wr(tcm_pkg::ADDR_ENPOL, 32'h1100);
        wr(tcm_pkg::ADDR_MODE, 32'h5656);
        rd_reg(tcm_pkg::ADDR_MODE);
        chk(rd, 32'h5555);
        chk({en4, en3}, 2'b11);
        wr(tcm_pkg::ADDR_ENPOL, 32'h0);
        wr(tcm_pkg::ADDR_MODE, 32'h0202);
        rd_reg(tcm_pkg::ADDR_MODE);
        chk(rd, 32'h0202);
        // Every prescaler ratio on both channels
        for (c = 0; c < 2; c++) begin
            for (s = 0; s < 4; s++) begin
                wr(tcm_pkg::ADDR_MODE, 32'((s << 2) | 1) << (8 * c));
                wr(tcm_pkg::ADDR_ENPOL, 32'h100 << (4 * c));
                idle(8);
                cap[c] = 0;
                pulse(c, 8, 3);
                idle(8);
                chk(32'(cap[c]), 32'(8 >> s));
                wr(tcm_pkg::ADDR_ENPOL, 32'h0);
            end
        end
        // No capture while the channel is disabled
        wr(tcm_pkg::ADDR_MODE, 32'h0001);
        cap[0] = 0;
        pulse(0, 4, 3);
        idle(8);
        chk(32'(cap[0]), 32'h0);
        // Inverted polarity captures on the falling edge only
        wr(tcm_pkg::ADDR_ENPOL, 32'h0300);
        idle(8);
        cap[0] = 0;
        want <= 3'h1;
        idle(10);
        chk(32'(cap[0]), 32'h0);
        chk(f3, 1'b0);
        want <= 3'h0;
        idle(10);
        chk(32'(cap[0]), 32'h1);
        chk(f3, 1'b1);
        wr(tcm_pkg::ADDR_ENPOL, 32'h0);
        // Single-cycle glitch passes unfiltered, is dropped when filtered
        idle(8);
        seen3 = 1'b0;
        pulse(0, 1, 1);
        idle(10);
        chk(seen3, 1'b1);
        wr(tcm_pkg::ADDR_MODE, 32'h0011);
        idle(8);
        seen3 = 1'b0;
        pulse(0, 1, 1);
        idle(10);
        chk(seen3, 1'b0);
        pulse(0, 1, 6);
        idle(10);
        chk(seen3, 1'b1);
        // Unmapped address
        rd_reg(12'h0fc);
        chk(resp, tcm_pkg::RESP_SLVERR);
        chk(rd, 32'h0);
        wr(12'h0fc, 32'h0000_00ff);
        chk(resp, tcm_pkg::RESP_SLVERR);
        // Ch3 input with routing live and low level, ch4 output
        rd_reg(tcm_pkg::ADDR_STATUS);
        chk(rd, 32'h0000_0006);
        complete_run();
    end
endmodule

`default_nettype wire

// >>> sim/tcm_pin_model.sv
// Purpose: Far-side model of the timer input pins and the internal trigger source
// Assumes: The bench asks for pin levels just after a rising edge
// Notes:   Levels asked for appear at the next edge, as a synchronous pin would
`default_nettype none

module tcm_pin_model (
    input  wire logic       aclk,
    input  wire logic [2:0] want,
    output logic            pin_three,
    output logic            pin_four,
    output logic            trig
);
    timeunit 1ns;
    timeprecision 1ps;

    initial {trig, pin_four, pin_three} = 3'h0;

    always @(posedge aclk) begin
        {trig, pin_four, pin_three} <= want;
    end
endmodule

`default_nettype wire
